// >>> rtl/cw_pkg.sv
// Constants for the drive control word composer: register map, field
// positions, reset values and the order of words in an outgoing frame.
// Assumes a 32-bit APB register bus and 16-bit link words.
package cw_pkg;

  localparam int unsigned LINK_W      = 16;
  localparam int unsigned FRAME_WORDS = 4;
  localparam int unsigned FIFO_DEPTH  = 16;

  // Register byte addresses
  localparam logic [7:0] AXIS_CTRL_OFS = 8'h00;
  localparam logic [7:0] REQUEST_OFS   = 8'h04;
  localparam logic [7:0] SPEED_OFS     = 8'h08;
  localparam logic [7:0] TORQUE_OFS    = 8'h0c;
  localparam logic [7:0] WORDS_OFS     = 8'h10;
  localparam logic [7:0] FLAGS_OFS     = 8'h14;

  // Axis control register fields
  localparam int unsigned AX_SERVO_EN   = 0;
  localparam int unsigned AX_MEAS_SEL   = 1;
  localparam int unsigned AX_MEAS_OK    = 2;
  localparam int unsigned AX_PULSE_EN   = 3;
  localparam int unsigned AX_RAMP_REL   = 4;
  localparam int unsigned AX_BRAKE_REL  = 5;
  localparam int unsigned AX_FGEN_SEL   = 6;
  localparam int unsigned AX_CAN_CTRL   = 7;
  localparam int unsigned AX_CUSTOMER   = 8;
  localparam int unsigned AX_LINK_EN    = 9;
  localparam int unsigned AX_W          = 10;
  localparam logic [9:0]  AX_RESET     = 10'h000;

  // Request register field (write one to request)
  localparam int unsigned RQ_FAULT_RST  = 0;

  // Flags register fields
  localparam int unsigned FL_DROPPED    = 0;
  localparam int unsigned FL_RST_PEND   = 1;
  localparam int unsigned FL_BUSY       = 2;
  localparam int unsigned FL_LEVEL_LSB  = 8;

  // Control word bit positions
  localparam int unsigned CW_RAMP_STOP  = 0;
  localparam int unsigned CW_COAST_STOP = 1;
  localparam int unsigned CW_QUICK_STOP = 2;
  localparam int unsigned CW_INV_EN     = 3;
  localparam int unsigned CW_RAMP_EN    = 4;
  localparam int unsigned CW_RAMP_START = 5;
  localparam int unsigned CW_SETP_EN    = 6;
  localparam int unsigned CW_FAULT_RST  = 7;
  localparam int unsigned CW_FGEN       = 8;
  localparam int unsigned CW_CTRL_REQ   = 10;
  localparam int unsigned CW_BRAKE      = 12;
  localparam int unsigned CW_RAMP_ZERO  = 13;
  localparam int unsigned CW_CUSTOMER   = 15;

  // Status word one bit positions
  localparam int unsigned SW_FAULT      = 3;
  localparam int unsigned SW_FAULT_ALT  = 6;
  localparam int unsigned SW_CTRL_REQ   = 9;

  localparam logic [15:0] SPEED_HI_RESET = 16'h0000;
  localparam logic [31:0] SPEED_RESET    = 32'h0000_0000;
  localparam logic [15:0] TORQUE_RESET   = 16'h0000;
  localparam logic [15:0] WORD_RESET     = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CTRL   = 3'b001,
    ST_SPD_HI = 3'b010,
    ST_SPD_LO = 3'b011,
    ST_TORQUE = 3'b100
  } frame_state_t;

endpackage

// >>> rtl/word_fifo.sv
// Word FIFO with a registered read port.
// Assumes one clock, an active-low asynchronous reset and a clock enable.
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1):0]        level
);
  localparam int unsigned AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("word_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;

  wire push = in_valid && in_ready;
  wire pop  = (cnt_q != '0) && (!out_valid_q || out_ready);

  assign in_ready  = (cnt_q < (AW+1)'(DEPTH));
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;
  assign level     = ($clog2(DEPTH+1)+1)'(cnt_q) +
                     ($clog2(DEPTH+1)+1)'(out_valid_q);

  // Storage carries no reset so it can map onto plain RAM
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else if (ce) begin
      if (push) wr_ptr_q <= wr_ptr_q + AW'(1);
      if (pop)  rd_ptr_q <= rd_ptr_q + AW'(1);
      if (push && !pop) cnt_q <= cnt_q + (AW+1)'(1);
      else if (pop && !push) cnt_q <= cnt_q - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else if (ce) begin
      if (pop) begin
        out_valid_q <= 1'b1;
        out_data_q  <= mem_q[rd_ptr_q];
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/drive_control_word_composer.sv
// Composes drive_control_word_one and streams it, followed by the speed
// and torque setpoints, as one frame per frame tick toward the drive.
// Assumes frame_tick, drive_status_word_one and the link handshake come
// from logic on pclk; software reaches the registers over APB.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module drive_control_word_composer
  import cw_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              frame_tick,
  input  wire logic [LINK_W-1:0] drive_status_word_one,
  output logic [LINK_W-1:0]      link_word,
  output logic                   link_first,
  output logic                   link_valid,
  input  wire logic              link_ready
);
  localparam int unsigned FW = LINK_W + 1;
  localparam int unsigned LW = $clog2(DEPTH+1) + 1;

  generate
    if (DEPTH < FRAME_WORDS || DEPTH > 255) begin : g_bad_depth
      $error("FIFO depth must hold one frame and fit the level field");
    end
    // The sequencer below is written for exactly four 16-bit words
    if (FRAME_WORDS != 4 || LINK_W != 16) begin : g_bad_frame
      $error("frame layout differs from the fixed sequencer order");
    end
    if (AX_LINK_EN >= AX_W || AX_CUSTOMER >= AX_W) begin : g_bad_axis
      $error("axis control fields exceed the register width");
    end
    if (FL_LEVEL_LSB + LW > 32) begin : g_bad_flags
      $error("FIFO level does not fit the flags register");
    end
    if (CW_CUSTOMER >= LINK_W || SW_CTRL_REQ >= LINK_W) begin : g_bad_word
      $error("control or status bit outside the link word");
    end
  endgenerate

  // Register state
  logic [AX_W-1:0]   axis_q;
  logic [31:0]       speed_q;
  logic [15:0]       torque_q;
  logic [15:0]       last_cw_q;
  logic              dropped_q;
  logic              rst_pend_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;

  // Frame state
  frame_state_t      state_q;
  frame_state_t      state_d;
  logic [15:0]       cw_q;
  logic [31:0]       spd_snap_q;
  logic [15:0]       trq_snap_q;

  // FIFO wires
  logic              fifo_in_ready;
  logic [LW-1:0]     fifo_level;
  logic [FW-1:0]     fifo_out;

  // One aligned word per register; no byte lanes to decode
  function automatic logic reg_hit(
    input logic [7:0] a,
    input logic [7:0] ofs
  );
    return (a == ofs);
  endfunction

  // APB decode
  wire access   = psel && penable && !pready_q;
  wire commit   = psel && penable && pready_q;
  wire wr_en    = commit && pwrite;
  wire hit_axis = reg_hit(paddr, AXIS_CTRL_OFS);
  wire hit_req  = reg_hit(paddr, REQUEST_OFS);
  wire hit_spd  = reg_hit(paddr, SPEED_OFS);
  wire hit_trq  = reg_hit(paddr, TORQUE_OFS);
  wire hit_word = reg_hit(paddr, WORDS_OFS);
  wire hit_flag = reg_hit(paddr, FLAGS_OFS);
  wire mapped   = hit_axis || hit_req || hit_spd || hit_trq ||
                  hit_word || hit_flag;
  wire frame_busy = (state_q != ST_IDLE);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_axis) begin
      rd_mux[AX_W-1:0] = axis_q;
    end else if (hit_req) begin
      // Request strobes are write-only and read back as zero
      rd_mux = 32'h0000_0000;
    end else if (hit_spd) begin
      rd_mux = speed_q;
    end else if (hit_trq) begin
      rd_mux[15:0] = torque_q;
    end else if (hit_word) begin
      rd_mux = {drive_status_word_one, last_cw_q};
    end else if (hit_flag) begin
      rd_mux[FL_DROPPED]  = dropped_q;
      rd_mux[FL_RST_PEND] = rst_pend_q;
      rd_mux[FL_BUSY]     = frame_busy;
      rd_mux[FL_LEVEL_LSB +: LW] = fifo_level;
    end
  end

  // Axis condition decode
  wire servo_en   = axis_q[AX_SERVO_EN];
  wire meas_good  = axis_q[AX_MEAS_SEL] && axis_q[AX_MEAS_OK];
  wire pulse_en   = axis_q[AX_PULSE_EN];
  wire ramp_rel   = axis_q[AX_RAMP_REL];
  wire link_en    = axis_q[AX_LINK_EN];

  // Status word is used as is: it arrives on pclk
  // Drive fault seen in status word one
  wire drive_fault = drive_status_word_one[SW_FAULT] ||
                     drive_status_word_one[SW_FAULT_ALT];
  wire rst_req     = wr_en && hit_req && pwdata[RQ_FAULT_RST];
  wire rst_set     = rst_req && drive_fault;

  // Composition of the control word for the coming frame
  wire ramp_stop_ok = servo_en && meas_good && pulse_en;
  wire fault_rst    = rst_pend_q || rst_set;
  wire ramp_stop_inactive = ramp_stop_ok && !fault_rst;

  logic [15:0] cw_next;
  always_comb begin
    cw_next = 16'h0000;
    cw_next[CW_RAMP_STOP]  = ramp_stop_inactive;
    cw_next[CW_COAST_STOP] = 1'b1;
    cw_next[CW_QUICK_STOP] = 1'b1;
    cw_next[CW_INV_EN]     = pulse_en;
    cw_next[CW_RAMP_EN]    = ramp_rel;
    cw_next[CW_RAMP_START] = ramp_rel;
    cw_next[CW_SETP_EN]    = ramp_stop_inactive;
    cw_next[CW_FAULT_RST]  = fault_rst;
    cw_next[CW_FGEN]       = axis_q[AX_FGEN_SEL];
    cw_next[CW_CTRL_REQ]   = axis_q[AX_CAN_CTRL] &&
                             drive_status_word_one[SW_CTRL_REQ];
    cw_next[CW_BRAKE]      = axis_q[AX_BRAKE_REL];
    cw_next[CW_RAMP_ZERO]  = 1'b1;
    // Passed through only; the drive leaves it unused
    cw_next[CW_CUSTOMER]   = axis_q[AX_CUSTOMER];
  end

  // A frame starts only with room for all its words, so it is never split
  wire room       = (fifo_level <= LW'(DEPTH - FRAME_WORDS));
  wire start      = frame_tick && link_en && (state_q == ST_IDLE);
  wire start_ok   = start && room;
  // A tick that cannot start a frame while the link is enabled is flagged as dropped
  wire tick_lost  = frame_tick && link_en && !start_ok;

  // Word on the FIFO input for the current state
  logic [FW-1:0] push_word;
  logic          push_valid;
  always_comb begin
    push_word  = {1'b0, WORD_RESET};
    push_valid = 1'b1;
    case (state_q)
      ST_CTRL:   push_word = {1'b1, cw_q};
      ST_SPD_HI: push_word = {1'b0, spd_snap_q[31:16]};
      ST_SPD_LO: push_word = {1'b0, spd_snap_q[15:0]};
      ST_TORQUE: push_word = {1'b0, trq_snap_q};
      default:   push_valid = 1'b0;
    endcase
  end
  wire push_done = push_valid && fifo_in_ready;

  // Frame sequencer: control word first, then setpoints
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:   if (start_ok) state_d = ST_CTRL;
      ST_CTRL:   if (push_done) state_d = ST_SPD_HI;
      ST_SPD_HI: if (push_done) state_d = ST_SPD_LO;
      ST_SPD_LO: if (push_done) state_d = ST_TORQUE;
      ST_TORQUE: if (push_done) state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_IDLE;
      cw_q       <= WORD_RESET;
      spd_snap_q <= SPEED_RESET;
      trq_snap_q <= TORQUE_RESET;
    end else if (ce) begin
      state_q <= state_d;
      // Snapshot keeps a frame consistent against mid-frame writes
      if (start_ok) begin
        cw_q       <= cw_next;
        spd_snap_q <= speed_q;
        trq_snap_q <= torque_q;
      end
    end
  end

  // Pending fault reset: a new request beats the frame that clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pend_q <= 1'b0;
      last_cw_q  <= WORD_RESET;
    end else if (ce) begin
      if (rst_set) rst_pend_q <= 1'b1;
      else if (start_ok) rst_pend_q <= 1'b0;
      if (state_q == ST_CTRL && push_done) last_cw_q <= cw_q;
    end
  end

  // Dropped-frame flag: set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dropped_q <= 1'b0;
    end else if (ce) begin
      if (tick_lost) dropped_q <= 1'b1;
      else if (wr_en && hit_flag && pwdata[FL_DROPPED]) dropped_q <= 1'b0;
    end
  end

  // Software-owned registers; writes land at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axis_q   <= AX_RESET;
      speed_q  <= SPEED_RESET;
      torque_q <= TORQUE_RESET;
    end else if (ce && wr_en) begin
      if (hit_axis) axis_q   <= pwdata[AX_W-1:0];
      if (hit_spd)  speed_q  <= pwdata;
      if (hit_trq)  torque_q <= pwdata[15:0];
    end
  end

  // APB answer: one wait cycle, error on unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      pready_q  <= access;
      pslverr_q <= access && !mapped;
      // Read data captured in the wait cycle, stands with pready
      if (access) prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Buffer absorbs link back-pressure for up to several frames
  word_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .ce        (ce),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (link_valid),
    .out_ready (link_ready),
    .out_data  (fifo_out),
    .level     (fifo_level)
  );

  // Top bit of each FIFO word marks the control word
  assign link_word  = fifo_out[LINK_W-1:0];
  assign link_first = fifo_out[LINK_W];
endmodule
`default_nettype wire

// >>> tb/cw_asserts.sv
// Checker for the control word composer: link framing and APB timing.
// Bound onto the composer; sees only its top-level ports.
`timescale 1ns/1ns
`default_nettype none
module cw_asserts #(
  parameter int unsigned DEPTH = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] link_word,
  input wire logic        link_first,
  input wire logic        link_valid,
  input wire logic        link_ready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire cw_on;
  assign cw_on = link_valid && link_first;

  chk_valid_hold:
    assert property (link_valid && !link_ready |=> link_valid
      && $stable(link_word) && $stable(link_first)) else $error("word lost");
  chk_word_order:
    assert property (cw_on && link_ready |=> !cw_on)
      else $error("control word repeated");
  chk_bit0_pulse:
    assert property (cw_on && link_word[0] |-> link_word[3])
      else $error("bit 0 without pulse enable");
  chk_setp_mirror:
    assert property (cw_on |-> link_word[6] == link_word[0])
      else $error("bit 6 differs from bit 0");
  chk_reset_off:
    assert property (cw_on && link_word[7] |-> !link_word[0])
      else $error("bit 0 set with fault reset");
  chk_const_ones:
    assert property (cw_on |-> link_word[1] && link_word[2] && link_word[13])
      else $error("constant bits low");
  chk_ramp_pair:
    assert property (cw_on |-> link_word[4] == link_word[5])
      else $error("ramp bits differ");
  chk_unused_low:
    assert property (cw_on |-> !(link_word[9] | link_word[11] | link_word[14]))
      else $error("unused bit set");
  chk_apb_wait:
    assert property (psel && penable && !pready |=> pready)
      else $error("apb answer late");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("pready too long");
  chk_err_ready:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
endmodule

bind drive_control_word_composer cw_asserts #(.DEPTH(DEPTH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .link_word(link_word),
  .link_first(link_first), .link_valid(link_valid), .link_ready(link_ready)
);
`default_nettype wire

// >>> tb/drive_model.sv
// Drive at the far end of the link: takes words, returns status word one.
// Assumes the same clock as the composer; stall and slow come from the bench.
`timescale 1ns/1ns
`default_nettype none
module drive_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        link_valid,
  input  wire logic        link_first,
  input  wire logic [15:0] link_word,
  input  wire logic        stall,
  input  wire logic        slow,
  input  wire logic [15:0] st_in,
  output logic             link_ready,
  output logic [15:0]      drive_status_word_one
);
  logic [16:0] q[$];
  logic [3:0]  r_q;
  assign drive_status_word_one = st_in;
  // Ready follows a 4-bit LFSR pattern when slow, to stress the hold rule
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_ready <= 1'b0;
      r_q        <= 4'h9;
    end else begin
      r_q        <= {r_q[2:0], r_q[3] ^ r_q[2]};
      link_ready <= !stall && (!slow || r_q[0]);
    end
  end
  // Bit 15 is stored for the bench only; the drive never acts on it
  always @(posedge pclk) begin
    if (presetn && link_valid && link_ready)
      q.push_back({link_first, link_word});
  end
endmodule
`default_nettype wire

// >>> tb/drive_control_word_composer_test.sv
// Self-checking bench for the control word composer.
// Assumes the drive model answers the link; APB master lives here.
`timescale 1ns/1ns
`default_nettype none
module drive_control_word_composer_test;
  import cw_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, frame_tick;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, sp;
  logic        pready, pslverr, err, link_first, link_valid, link_ready;
  logic        stall, slow;
  logic [15:0] st, sw, link_word, seed, tq;
  logic [9:0]  ax;
  int          fail_count, n_tests, cyc;

  drive_control_word_composer DUT (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_tick(frame_tick),
    .drive_status_word_one(sw), .link_word(link_word),
    .link_first(link_first), .link_valid(link_valid),
    .link_ready(link_ready));
  drive_model m (.pclk(pclk), .presetn(presetn), .link_valid(link_valid),
    .link_first(link_first), .link_word(link_word), .stall(stall),
    .slow(slow), .st_in(st), .link_ready(link_ready),
    .drive_status_word_one(sw));

  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] ecw(logic [9:0] a, logic [15:0] s,
                                      logic f);
    logic [15:0] c;
    c = 16'h2006;
    c[0] = &a[3:0] & !f;
    c[3] = a[3];
    c[5:4] = {2{a[4]}};
    c[6] = c[0];
    c[7] = f;
    c[8] = a[6];
    c[10] = a[7] & s[9];
    c[12] = a[5];
    c[15] = a[8];
    return c;
  endfunction

  task chk(string n, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (++cyc > 20000) begin
      fail_count++;
      wrap_up;
    end
  end

  // Request held until pready is sampled, released at that edge only
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task tk;
    @(posedge pclk);
    frame_tick <= 1'b1;
    @(posedge pclk);
    frame_tick <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task frame(logic [9:0] a, logic [31:0] s, logic [15:0] q, logic f);
    logic [16:0] x [4];
    logic [16:0] w;
    int n;
    apb(1, AXIS_CTRL_OFS, {22'h0, a});
    apb(1, SPEED_OFS, s);
    apb(1, TORQUE_OFS, {16'h0, q});
    x = '{{1'b1, ecw(a, st, f)}, {1'b0, s[31:16]}, {1'b0, s[15:0]},
          {1'b0, q}};
    tk;
    n = 0;
    while (m.q.size() < 4 && n++ < 300) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      w = m.q.size() ? m.q.pop_front() : 17'h0;
      chk("frame word", 32'(x[i]), 32'(w));
    end
    apb(0, WORDS_OFS, 0);
    chk("words reg", {st, x[0][15:0]}, r);
  endtask

  initial begin
    {ce, presetn, psel, penable, pwrite, frame_tick} = 6'b100000;
    {paddr, pwdata, st, stall, slow, seed} = {40'h0, 16'h0, 2'b0, 16'h235e};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(0, 8'(i * 4), 0);
      chk("reset value", 0, r);
    end
    apb(1, 8'h1c, 32'hffff_ffff);
    apb(0, 8'h18, 0);
    chk("unmapped err", 1, 32'(err));
    chk("unmapped data", 0, r);
    for (int k = 0; k < 14; k++) begin
      seed = nx(seed);
      ax = {1'b1, seed[8:0]} | (k[0] ? 10'h00f : 10'h000);
      seed = nx(seed);
      sp = {seed, nx(seed)};
      tq = ~seed;
      st <= nx(nx(seed)) & 16'hffb7;
      slow <= seed[3];
      frame(ax, sp, tq, 1'b0);
    end
    for (int k = 0; k < 3; k++) begin
      st <= k == 0 ? 16'h0008 : k == 1 ? 16'h0040 : 16'h0200;
      apb(1, REQUEST_OFS, 1);
      apb(0, FLAGS_OFS, 0);
      chk("pending", k < 2 ? 2 : 0, r);
      frame(10'h3ff, 32'h1234_5678, 16'h9abc, k < 2);
    end
    stall <= 1'b1;
    repeat (6) tk;
    apb(0, FLAGS_OFS, 0);
    chk("fifo full", 32'h1001, r);
    apb(1, FLAGS_OFS, 1);
    apb(0, FLAGS_OFS, 0);
    chk("drop cleared", 32'h1000, r);
    stall <= 1'b0;
    repeat (80) @(posedge pclk);
    chk("drained", 16, m.q.size());
    m.q.delete();
    apb(0, FLAGS_OFS, 0);
    chk("fifo empty", 0, r);
    ce <= 1'b0;
    tk;
    repeat (20) @(posedge pclk);
    chk("ce frozen", 0, m.q.size());
    ce <= 1'b1;
    apb(0, FLAGS_OFS, 0);
    chk("ce no drop", 0, r);
    apb(1, AXIS_CTRL_OFS, 0);
    tk;
    repeat (20) @(posedge pclk);
    chk("link off", 0, m.q.size());
    wrap_up;
  end
endmodule
`default_nettype wire
